//--- rtl/filter_sync_defines.svh
// Timing constants and the result width for the filter synchroniser block.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef FILTER_SYNC_DEFINES_SVH
`define FILTER_SYNC_DEFINES_SVH

// Decimation ratio of the filter sequencer, in master clock cycles per result.
`define DECIM_RATIO       6'h20
// Results discarded after synchronisation while the filter settles.
`define SETTLE_RESULTS    4'h4
// Cycles the data-ready output stays high around each output update.
`define UPDATE_HIGH_CYCLES 2'h2
// Width of the output result word.
`define RESULT_WIDTH      16

`endif

//--- rtl/filter_sync_pkg.sv
// Types shared by the filter synchroniser block.
// Assumes nothing beyond a SystemVerilog compiler.
package filter_sync_pkg;
	typedef enum logic [2:0] {
		ST_HOLD   = 3'b001,
		ST_SETTLE = 3'b010,
		ST_RUN    = 3'b100
	} seq_state_t;
endpackage

//--- rtl/filter_sync_clock_select.sv
// Decimation filter sequencer synchronisation and master clock source selection.
// Assumes the sync input is driven by logic on the master clock, launched on its falling edge.
//
// Notes on behaviour
// - Sync is accepted the same way whatever data interface mode is selected.
// - A rising edge on sync clears the filter sequencer counter to zero.
// - The filter is held in reset while sync is high and released on an edge seeing it low.
// - Sample accumulation starts from the edge on which the filter leaves reset.
// - Parts sharing clock and sync update their output registers in the same cycle.
// - Data-ready is driven high after sync and kept high until a settled result exists.
// - With the oscillator disable pin low the on-chip oscillator supplies the master clock.
// - With the oscillator disable pin high an external clock supplies the master clock.
// - Data-ready goes high for two cycles around each update, new data loaded after its rise.
`timescale 1ns/1ps
`include "filter_sync_defines.svh"

module filter_sync_clock_select #(
	parameter int RESULT_W = `RESULT_WIDTH
) (
	// Clock, reset and enable
	input  wire logic                ref_clk_in,
	input  wire logic                rst_n_in,
	input  wire logic                clk_en_in,
	// Clock source selection
	input  wire logic                crystal_osc_disable_in,
	input  wire logic                xtal_clk_in,
	input  wire logic                ext_clk_in,
	output logic                     osc_enable_out,
	output logic                     master_clock_out,
	// Synchronisation and data path
	input  wire logic                sync_in,
	input  wire logic [RESULT_W-1:0] filter_result_in,
	output logic [RESULT_W-1:0]      result_data_out,
	output logic                     result_valid_n_out,
	output logic                     filter_reset_out,
	output logic [5:0]               seq_count_out
);

	// ************************************************************
	// Clock source selection
	// ************************************************************
	// Static strap steering the analog clock mux; not retimed since it never toggles in use.
	assign osc_enable_out   = ~crystal_osc_disable_in;
	assign master_clock_out = crystal_osc_disable_in ? ext_clk_in
	                                                 : xtal_clk_in;

	// ************************************************************
	// Sync sampling
	// ************************************************************
	// Sync is synchronous to the master clock, so one register suffices for edge finding.
	logic                      sync_r;
	logic                      sync_rise;
	filter_sync_pkg::seq_state_t state_r;
	logic [5:0]                count_r;
	logic [3:0]                settle_r;
	logic [1:0]                high_cnt_r;
	logic                      update;
	logic                      have_result_r;

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sync_r <= 1'b0;
		end else if (clk_en_in) begin
			sync_r <= sync_in;
		end
	end

	// Mode pins are not inputs here, so sync behaves identically in every interface mode.
	assign sync_rise = sync_in & ~sync_r;

	// ************************************************************
	// Filter sequencer
	// ************************************************************
	assign update = (state_r != filter_sync_pkg::ST_HOLD)
	              && (count_r == `DECIM_RATIO - 6'h01);

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_r  <= filter_sync_pkg::ST_HOLD;
			count_r  <= 6'h00;
			settle_r <= 4'h0;
		end else if (clk_en_in) begin
			if (sync_rise || sync_in) begin
				state_r  <= filter_sync_pkg::ST_HOLD;
				count_r  <= 6'h00;
				settle_r <= 4'h0;
			end else begin
				case (state_r)
					filter_sync_pkg::ST_HOLD: begin
						// Leaving reset on this edge aligns all parts on the shared clock.
						state_r <= filter_sync_pkg::ST_SETTLE;
						count_r <= 6'h01;
					end
					filter_sync_pkg::ST_SETTLE: begin
						count_r <= update ? 6'h00 : count_r + 6'h01;
						if (update) begin
							settle_r <= settle_r + 4'h1;
							if (settle_r == `SETTLE_RESULTS - 4'h1) begin
								state_r <= filter_sync_pkg::ST_RUN;
							end
						end
					end
					filter_sync_pkg::ST_RUN: begin
						count_r <= update ? 6'h00 : count_r + 6'h01;
					end
					default: begin
						state_r <= filter_sync_pkg::ST_HOLD;
						count_r <= 6'h00;
					end
				endcase
			end
		end
	end

	assign filter_reset_out = (state_r == filter_sync_pkg::ST_HOLD);
	assign seq_count_out    = count_r;

	// ************************************************************
	// Output register and data-ready
	// ************************************************************
	// The update point is a fixed count from sync release, so shared-sync parts load together.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			result_data_out <= '0;
		end else if (clk_en_in && update && !sync_in && state_r == filter_sync_pkg::ST_RUN) begin
			result_data_out <= filter_result_in;
		end
	end

	// Data-ready may only fall once a word loaded since the last sync sits in the register.
	// Without this flag the first run period would offer the stale pre-sync word as valid.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			have_result_r <= 1'b0;
		end else if (clk_en_in) begin
			if (sync_in || state_r != filter_sync_pkg::ST_RUN) begin
				have_result_r <= 1'b0;
			end else if (update) begin
				have_result_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			high_cnt_r         <= 2'h0;
			result_valid_n_out <= 1'b1;
		end else if (clk_en_in) begin
			if (sync_in || state_r != filter_sync_pkg::ST_RUN || !have_result_r) begin
				high_cnt_r         <= 2'h0;
				result_valid_n_out <= 1'b1;
			end else if (count_r == `DECIM_RATIO - 6'h02) begin
				// High one cycle before the load so old data can be latched on the rise.
				high_cnt_r         <= `UPDATE_HIGH_CYCLES - 2'h1;
				result_valid_n_out <= 1'b1;
			end else if (high_cnt_r != 2'h0) begin
				high_cnt_r         <= high_cnt_r - 2'h1;
				result_valid_n_out <= 1'b1;
			end else begin
				result_valid_n_out <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_sync_clears_count: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && sync_in && !sync_r |=> count_r == 6'h00)
		else $error("sequencer not cleared by sync rise");

	a_hold_while_high: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && sync_in |=> filter_reset_out)
		else $error("filter left reset while sync high");

	a_release_on_low: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && filter_reset_out && !sync_in |=> !filter_reset_out && count_r == 6'h01)
		else $error("filter not released when sync low");

	a_ready_high_sync: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && sync_in |=> result_valid_n_out)
		else $error("data-ready low after sync");

	a_ready_settling: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		state_r != filter_sync_pkg::ST_RUN |=> result_valid_n_out)
		else $error("data-ready low before settling");

	a_update_pulse: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && state_r == filter_sync_pkg::ST_RUN && !sync_in
		&& count_r == `DECIM_RATIO - 6'h02 && $past(!result_valid_n_out)
		##1 clk_en_in && !sync_in ##1 clk_en_in && !sync_in
		|-> result_valid_n_out && $past(result_valid_n_out) ##1 !result_valid_n_out || !clk_en_in || sync_in)
		else $error("data-ready high pulse not two cycles");

	a_osc_select: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		osc_enable_out == !crystal_osc_disable_in)
		else $error("oscillator enable mismatch");

	a_sync_sampled: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in |=> sync_r == $past(sync_in))
		else $error("sync not registered");

	a_first_load_ready: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		!have_result_r |-> result_valid_n_out)
		else $error("data-ready low before the first result after sync");

	a_load_on_update: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && update && !sync_in && state_r == filter_sync_pkg::ST_RUN
		|=> result_data_out == $past(filter_result_in))
		else $error("output register not loaded at the update point");

	a_count_wrap: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		clk_en_in && !sync_in && !filter_reset_out && count_r == `DECIM_RATIO - 6'h01
		|=> count_r == 6'h00)
		else $error("sequencer did not wrap after a full period");

	a_enable_freeze: assert property (
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		!clk_en_in |=> $stable(count_r) && $stable(result_valid_n_out))
		else $error("state moved while the clock enable was low");

endmodule

//--- verif/sync_host.sv
// Host model that drives the sync line of the converter.
// Assumes it shares the master clock with the block.
`timescale 1ns/1ps
module sync_host (
	input  wire logic clk_in,
	input  wire logic pulse_in,
	output logic      sync_out
);
	// Launched on the falling edge, so the next rising edge sees a settled level.
	always @(negedge clk_in) begin
		sync_out <= pulse_in;
	end
endmodule

//--- verif/tb.sv
// Self-checking bench for the filter synchroniser and clock select.
// Assumes the design files under rtl/ are compiled first.
`timescale 1ns/1ps
module tb;
	// ********************************
	// Stimulus, model and checks
	// ********************************
	logic        ref_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        en = 1'b1, dis = 1'b0, xtal = 1'b0, ext = 1'b0, pulse = 1'b0;
	logic        sync, osc_en, mclk, rst_f, vn, prev_v = 1'b1;
	logic [15:0] fres = 16'h0000, dout;
	logic [5:0]  cnt_o;
	integer      cnt = 0, st = 0, hold = 1, dval = 0, cyc = 0, i;
	integer      seed = 22841, n_fail = 0, samples_checked = 0;
	always #50 ref_clk_in = ~ref_clk_in;
	sync_host host (.clk_in(ref_clk_in), .pulse_in(pulse), .sync_out(sync));
	filter_sync_clock_select dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.clk_en_in(en), .crystal_osc_disable_in(dis), .xtal_clk_in(xtal),
		.ext_clk_in(ext), .osc_enable_out(osc_en), .master_clock_out(mclk),
		.sync_in(sync), .filter_result_in(fres), .result_data_out(dout),
		.result_valid_n_out(vn), .filter_reset_out(rst_f), .seq_count_out(cnt_o));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Cycle ceiling: the scenarios need about 1,510 cycles, so twice that means a hang.
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	// Reference model; a frozen enable leaves every count where it was.
	always @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			cnt = 0;
			st = 0;
			hold = 1;
		end else if (en) begin
			if (sync) begin
				cnt = 0;
				st = 0;
				hold = 1;
			end else begin
				if (cnt == 31) begin
					if (st >= 4) dval = filter_result_in_val();
					st = (st < 5) ? st + 1 : 5;
				end
				cnt = (cnt + 1) % 32;
				hold = 0;
			end
		end
	end
	function automatic integer filter_result_in_val();
		return fres;
	endfunction
	always @(negedge ref_clk_in) begin
		if (rst_n_in) begin
			chk("filter_reset", hold[15:0], {15'h0000, rst_f});
			chk("seq_count", cnt[15:0], {10'h000, cnt_o});
			if (st < 5) chk("ready_high", 16'h0001, {15'h0000, vn});
			else chk("ready_run", {15'h0000, (cnt == 31 || cnt == 0)}, {15'h0000, vn});
			if (prev_v === 1'b1 && vn === 1'b0) chk("data", dval[15:0], dout);
		end
		chk("osc_enable", {15'h0000, ~dis}, {15'h0000, osc_en});
		chk("master_clock", {15'h0000, dis ? ext : xtal}, {15'h0000, mclk});
		prev_v = vn;
	end
	initial begin
		repeat (5) @(negedge ref_clk_in);
		rst_n_in <= 1'b1;
		// Pulses cover a lone pulse, a long hold and two close pulses.
		for (i = 0; i < 1500; i++) begin
			@(negedge ref_clk_in);
			en <= ($random(seed) % 16) != 0;
			dis <= 1'($random(seed));
			xtal <= 1'($random(seed));
			ext <= 1'($random(seed));
			if (cnt == 8) fres <= 16'($random(seed));
			pulse <= (i == 400) || (i >= 700 && i < 705) || (i == 1000) || (i == 1002);
		end
		end_of_test();
	end
endmodule
